// [hdl/trc_edge_detect.sv]
// Edge detector for the external input pin: one sample stage plus a history stage.
`timescale 1ns/1ns
`default_nettype none
module trc_edge_detect (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Pin and selection
	input  wire logic pinIn,
	input  wire logic selRising,
	// Results
	output logic      level,
	output logic      edgeSeen
);
	typedef struct packed {
		logic sample;
		logic prev;
		logic hit;
	} trc_edge_t;

	trc_edge_t state;
	trc_edge_t next_state;

	always_comb begin
		next_state        = state;
		next_state.sample = pinIn;
		next_state.prev   = state.sample;
		// Two successive samples differing in the selected direction give exactly one pulse per edge of that polarity.
		next_state.hit    = selRising ? (state.sample & ~state.prev)
		                              : (~state.sample & state.prev);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign level    = state.sample;
	assign edgeSeen = state.hit;
endmodule
`default_nettype wire

// [hdl/trc_pkg.sv]
// Package with register map, field positions, reset values and timing constants of the timer.
package trc_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_COUNT   = 4'h4;
	localparam logic [3:0] OFS_RELOAD  = 4'h8;
	localparam logic [3:0] OFS_STATUS  = 4'hC;
	localparam int         ADDR_W      = 4;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int CTRL_RUN       = 0;
	localparam int CTRL_CAPMODE   = 1;
	localparam int CTRL_UPDOWN    = 2;
	localparam int CTRL_EXTEN     = 3;
	localparam int CTRL_RISING    = 4;
	localparam int CTRL_PRESCALE  = 5;
	localparam int CTRL_W         = 6;
	localparam int CTRL_MASK_LSB  = 8;

	// Status bits: reload event and capture event.
	localparam int STAT_RELOAD    = 0;
	localparam int STAT_CAPTURE   = 1;
	localparam int STAT_W         = 2;

	// ------------------------------------------------------------
	// Reset values and fixed counts
	// ------------------------------------------------------------
	localparam logic [5:0]  CTRL_RESET   = 6'h00;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TOP    = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO   = 16'h0000;
	localparam int          PRESCALE_DIV = 12;
	localparam logic [3:0]  DIV_LAST     = 4'(PRESCALE_DIV - 1);

endpackage

// [hdl/trc_timer.sv]
// Top of the 16-bit reload/capture timer with its Wishbone register slave.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - The timer is a 16-bit counter working either in auto-reload mode or in capture mode.
// - With the prescale bit clear the counter steps once every twelve clock cycles.
// - The counter keeps running through overflow, underflow and capture while enabled.
// - Up-only auto-reload counts upward from the reload value and overflows past FFFF.
// - Up-only auto-reload can reload on overflow alone or also on a chosen pin edge.
// - An up-counting reload outside capture mode loads the software-written reload/capture register.
// - Up-only auto-reload raises an interrupt on every reload, overflow or edge caused.
// - In up/down mode the pin level picks the counting direction at each step.
// - Up/down mode raises no interrupt on reloads in either direction.
// - Counting up in up/down mode reloads from the register only on overflow past FFFF.
// - Counting down it underflows on reaching the register value and reloads FFFF.
// - Capture mode counts up from 0000, overflows at FFFF and reloads 0000.
// - In capture mode a chosen pin edge copies the count into the reload/capture register.
// - Capture mode raises an interrupt on every overflow reload and every capture.
module trc_timer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// External pin and interrupt
	input  wire logic        timerExternalInput,
	output logic             irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [trc_pkg::CTRL_W-1:0] ctrl;
		logic [trc_pkg::STAT_W-1:0] mask;
		logic [trc_pkg::STAT_W-1:0] status;
		logic [15:0]                gpTimerCount;
		logic [15:0]                reloadCaptureValue;
		logic [3:0]                 div;
		logic [31:0]                rdata;
		logic                       ack;
		logic                       irq;
	} trc_state_t;

	trc_state_t state;
	trc_state_t next_state;

	logic pinLevel;
	logic pinEdge;

	trc_edge_detect u_edge (
		.clk       (clk),
		.srst      (srst),
		.pinIn     (timerExternalInput),
		.selRising (state.ctrl[trc_pkg::CTRL_RISING]),
		.level     (pinLevel),
		.edgeSeen  (pinEdge)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic                       run;
		logic                       capMode;
		logic                       upDown;
		logic                       tick;
		logic                       access;
		logic [trc_pkg::STAT_W-1:0] setEv;
		logic [trc_pkg::STAT_W-1:0] clrEv;
		run     = state.ctrl[trc_pkg::CTRL_RUN];
		capMode = state.ctrl[trc_pkg::CTRL_CAPMODE];
		upDown  = state.ctrl[trc_pkg::CTRL_UPDOWN];
		tick    = 1'b0;
		setEv   = '0;
		clrEv   = '0;
		access  = wb_cyc_i & wb_stb_i & ~state.ack;
		next_state = state;

		// Divider: a prescaler-bypass bit lets the count step every clock.
		if (run) begin
			if (state.ctrl[trc_pkg::CTRL_PRESCALE]) begin
				tick = 1'b1;
			end else if (state.div == trc_pkg::DIV_LAST) begin
				tick           = 1'b1;
				next_state.div = '0;
			end else begin
				next_state.div = state.div + 4'h1;
			end
		end else begin
			next_state.div = '0;
		end

		// Counter; run alone keeps it going through every event.
		if (run && capMode) begin
			if (tick) begin
				if (state.gpTimerCount == trc_pkg::COUNT_TOP) begin
					next_state.gpTimerCount = trc_pkg::COUNT_ZERO;
					setEv[trc_pkg::STAT_RELOAD] = 1'b1;
				end else begin
					next_state.gpTimerCount = state.gpTimerCount + 16'h0001;
				end
			end
			if (pinEdge) begin
				next_state.reloadCaptureValue = state.gpTimerCount;
				setEv[trc_pkg::STAT_CAPTURE]  = 1'b1;
			end
		end else if (run && upDown) begin
			// No status bit is set here, so no interrupt arises.
			if (tick) begin
				if (pinLevel) begin
					if (state.gpTimerCount == trc_pkg::COUNT_TOP) begin
						next_state.gpTimerCount = state.reloadCaptureValue;
					end else begin
						next_state.gpTimerCount = state.gpTimerCount + 16'h0001;
					end
				end else if (state.gpTimerCount == state.reloadCaptureValue) begin
					next_state.gpTimerCount = trc_pkg::COUNT_TOP;
				end else begin
					next_state.gpTimerCount = state.gpTimerCount - 16'h0001;
				end
			end
		end else if (run) begin
			if (pinEdge && state.ctrl[trc_pkg::CTRL_EXTEN]) begin
				next_state.gpTimerCount = state.reloadCaptureValue;
				setEv[trc_pkg::STAT_RELOAD] = 1'b1;
			end else if (tick) begin
				if (state.gpTimerCount == trc_pkg::COUNT_TOP) begin
					next_state.gpTimerCount = state.reloadCaptureValue;
					setEv[trc_pkg::STAT_RELOAD] = 1'b1;
				end else begin
					next_state.gpTimerCount = state.gpTimerCount + 16'h0001;
				end
			end
		end

		// Register access; every access is answered one cycle after the strobe.
		next_state.ack   = access;
		next_state.rdata = '0;
		if (access && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				trc_pkg::OFS_CTRL: begin
					next_state.ctrl = wb_dat_i[trc_pkg::CTRL_W-1:0];
				end
				trc_pkg::OFS_COUNT: begin
					next_state.gpTimerCount[7:0] = wb_dat_i[7:0];
				end
				trc_pkg::OFS_RELOAD: begin
					next_state.reloadCaptureValue[7:0] = wb_dat_i[7:0];
				end
				trc_pkg::OFS_STATUS: begin
					clrEv = wb_dat_i[trc_pkg::STAT_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (access && wb_we_i && wb_sel_i[1]) begin
			case (wb_adr_i)
				trc_pkg::OFS_CTRL: begin
					next_state.mask =
						wb_dat_i[trc_pkg::CTRL_MASK_LSB +: trc_pkg::STAT_W];
				end
				trc_pkg::OFS_COUNT: begin
					next_state.gpTimerCount[15:8] = wb_dat_i[15:8];
				end
				trc_pkg::OFS_RELOAD: begin
					next_state.reloadCaptureValue[15:8] = wb_dat_i[15:8];
				end
				default: begin
				end
			endcase
		end
		if (access && !wb_we_i) begin
			case (wb_adr_i)
				trc_pkg::OFS_CTRL: begin
					next_state.rdata[trc_pkg::CTRL_W-1:0] = state.ctrl;
					next_state.rdata[trc_pkg::CTRL_MASK_LSB +: trc_pkg::STAT_W] = state.mask;
				end
				trc_pkg::OFS_COUNT: begin
					next_state.rdata[15:0] = state.gpTimerCount;
				end
				trc_pkg::OFS_RELOAD: begin
					next_state.rdata[15:0] = state.reloadCaptureValue;
				end
				trc_pkg::OFS_STATUS: begin
					next_state.rdata[trc_pkg::STAT_W-1:0] = state.status;
				end
				default: begin
				end
			endcase
		end

		// A hardware event in the clearing cycle wins over the clear.
		next_state.status = (state.status & ~clrEv) | setEv;
		next_state.irq    = |(next_state.status & next_state.mask);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state                    <= '0;
			state.ctrl               <= trc_pkg::CTRL_RESET;
			state.gpTimerCount       <= trc_pkg::COUNT_RESET;
			state.reloadCaptureValue <= trc_pkg::RELOAD_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign wb_dat_o = state.rdata;
	assign wb_ack_o = state.ack;
	assign irq      = state.irq;
endmodule
`default_nettype wire

// [tb/tb_trc_timer.sv]
// Self-checking bench of the reload/capture timer.
`timescale 1ns/1ns
`default_nettype none
module tb_trc_timer;
	typedef struct packed {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} trc_row_t;
	logic        clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, pinReq = 0;
	logic [3:0]  wbAdr = 4'h0, wbSel = 4'h3;
	logic [31:0] wbDatI = 32'h0, wbDatO, rd;
	logic        wbAck, irq, pin;
	int          err_total = 0, total_checks = 0;
	trc_row_t    rows [9] = '{{1'b0, 4'h0, 32'h0, 32'h0}, {1'b0, 4'h4, 32'h0, 32'h0},
		{1'b0, 4'h8, 32'h0, 32'h0}, {1'b0, 4'hC, 32'h0, 32'h0}, {1'b0, 4'h2, 32'h0, 32'h0},
		{1'b1, 4'h8, 32'h0000ABCD, 32'h0}, {1'b0, 4'h8, 32'h0, 32'h0000ABCD},
		{1'b1, 4'h0, 32'hFFFF033E, 32'h0}, {1'b0, 4'h0, 32'h0, 32'h0000033E}};
	trc_timer trc_timer_i (.clk(clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .timerExternalInput(pin), .irq(irq));
	trc_pin_model trc_pin_model_i (.clk(clk), .pinReq(pinReq), .pinOut(pin));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// The master waits for ack however long it takes; only the watchdog ends a hung cycle.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d = 32'h0);
		int n;
		n = 0;
		@(posedge clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (wbAck !== 1'b1);
		chk("ack edge", 32'h2, n);
		rd = wbDatO;
		{wbCyc, wbStb} <= 2'b00;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial forever #5 clk = ~clk;
	initial begin
		#100000;
		err_total++;
		stop_test();
	end
	initial begin
		tick(12);
		srst <= 1'b0;
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("row", rows[i].e, rd);
		end
		// A lane-0 write changes only the low byte of the reload value.
		wbSel <= 4'h1;
		wb(1, 4'h8, 32'h00005555);
		wb(0, 4'h8);
		chk("lane write", 32'h0000AB55, rd);
		wbSel <= 4'h3;
		// Overflow in up-only mode reloads the register value and interrupts.
		wb(1, 4'h8, 32'hFFF0);
		wb(1, 4'h4, 32'hFFF0);
		wb(1, 4'h0, 32'h121);
		tick(30);
		wb(0, 4'hC);
		chk("status", 1, rd);
		chk("irq", 1, irq);
		wb(1, 4'h0, 32'h120);
		wb(1, 4'hC, 32'h1);
		tick(3);
		chk("irq", 0, irq);
		wb(0, 4'h4);
		chk("count", 1, rd >= 32'hFFF0 && rd <= 32'hFFFF);
		// Without the bypass the count steps once every twelve clocks.
		wb(1, 4'h4, 32'h0);
		wb(1, 4'h0, 32'h1);
		tick(120);
		wb(1, 4'h0, 32'h0);
		wb(0, 4'h4);
		chk("divided", 1, rd >= 32'h9 && rd <= 32'hB);
		// Both directions of up/down mode stay inside the reload window, silently.
		for (int p = 0; p < 2; p++) begin
			pinReq <= p[0];
			wb(1, 4'h8, 32'hFFF8);
			wb(1, 4'h4, 32'hFFFF);
			wb(1, 4'h0, 32'h125);
			tick(40);
			wb(1, 4'h0, 32'h0);
			wb(0, 4'hC);
			chk("updown status", 0, rd);
			wb(0, 4'h4);
			chk("updown count", 1, rd >= 32'hFFF8);
		end
		// A rising pin edge reloads in up-only mode before any overflow.
		pinReq <= 1'b0;
		wb(1, 4'h8, 32'h1234);
		wb(1, 4'h4, 32'h0);
		wb(1, 4'h0, 32'h139);
		tick(10);
		pinReq <= 1'b1;
		tick(10);
		wb(1, 4'h0, 32'h0);
		wb(0, 4'h4);
		chk("edge reload", 1, rd >= 32'h1234 && rd <= 32'h1250);
		wb(0, 4'hC);
		chk("edge status", 1, rd);
		// Capture mode latches the count on the chosen edge.
		wb(1, 4'hC, 32'h3);
		pinReq <= 1'b0;
		wb(1, 4'h4, 32'h0);
		wb(1, 4'h0, 32'h233);
		tick(20);
		pinReq <= 1'b1;
		tick(6);
		wb(1, 4'h0, 32'h200);
		wb(0, 4'h8);
		chk("captured", 1, rd >= 32'h12 && rd <= 32'h23);
		wb(0, 4'hC);
		chk("cap status", 2, rd);
		chk("cap irq", 1, irq);
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		chk("irq after reset", 0, irq);
		wb(0, 4'h0);
		chk("ctrl after reset", 0, rd);
		// Capture on a falling edge, with the pin left high across the reset.
		wb(1, 4'h0, 32'h223);
		tick(5);
		pinReq <= 1'b0;
		tick(8);
		wb(1, 4'h0, 32'h200);
		wb(0, 4'h8);
		chk("fall capture", 1, rd >= 32'h8 && rd <= 32'hA);
		wb(0, 4'hC);
		chk("fall status", 2, rd);
		stop_test();
	end
endmodule
`default_nettype wire

// [tb/trc_pin_model.sv]
// Model of the source that drives the timer's external input pin.
`timescale 1ns/1ns
`default_nettype none
module trc_pin_model (
	input  wire logic clk,
	input  wire logic pinReq,
	output logic      pinOut
);
	// The pin moves just after an edge, so its edges stay at least one sample apart.
	initial begin
		pinOut = 1'b0;
		forever @(posedge clk) pinOut <= pinReq;
	end
endmodule
`default_nettype wire

// [tb/trc_timer_sva.sv]
// Checker of the timer's bus and interrupt ports.
`timescale 1ns/1ns
`default_nettype none
module trc_timer_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// Wishbone slave
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Pin and interrupt
	input wire logic        timerExternalInput,
	input wire logic        irq
);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_rd(logic [3:0] a);
		wb_ack_o && !wb_we_i && wb_adr_i == a;
	endsequence
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack lasted more than one cycle");
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("request not answered in the next cycle");
	property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without a request");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle)
		else $error("read data not zero outside ack");
	property p_wide; wb_ack_o && !wb_we_i && wb_adr_i != trc_pkg::OFS_CTRL
		|-> wb_dat_o[31:16] == 16'h0; endproperty
	a_wide: assert property (p_wide)
		else $error("value wider than sixteen bits");
	property p_ctrl; s_rd(trc_pkg::OFS_CTRL) |-> wb_dat_o[31:10] == 22'h0
		&& wb_dat_o[7:6] == 2'h0; endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control readback has stray bits");
	property p_stat; s_rd(trc_pkg::OFS_STATUS) |-> wb_dat_o[31:2] == 30'h0; endproperty
	a_stat: assert property (p_stat)
		else $error("status readback has stray bits");
	// The clearing write and its ack land on one edge, so the fall is seen beside the ack.
	property p_irq_fall; $fell(irq) |-> (wb_we_i && wb_ack_o) || $past(srst);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without a write");
	c_read: cover property (s_rd(trc_pkg::OFS_COUNT));
	c_irq_up: cover property ($rose(irq));
	c_irq_down: cover property ($fell(irq));
endmodule
bind trc_timer trc_timer_sva trc_timer_sva_i (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.timerExternalInput(timerExternalInput), .irq(irq));
`default_nettype wire
